// >>> design/acf_flow.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "acf_cfg.svh"
// Behaviour
// - trigger mode: restart also triggers automatically
// - restart mode: restart only loads commands
// - trigger during restart sets trigger error
// - fixed delay from trigger to sampling
// - every use case works single or double
// - restart with load-ok swaps command lists in double buffer mode
// - abort ends sequence; hardware clears abort bit
// - restart while busy aborts, sets restart error
// - after restart, trigger starts at list top
module acf_flow
(
  input  wire logic        clock,          // 50 MHz system clock
  input  wire logic        arst_n,         // async reset, active low
  input  wire logic [7:0]  addr,           // register byte address
  input  wire logic [31:0] wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic      [31:0] rdata,          // read data, cycle after rd
  input  wire logic        seq_done,       // converter finished its sequence
  output logic             sample_start,   // pulse: sampling phase begins
  output logic             list_top,       // pulse: restart from list top
  output logic             active_list,    // selected command list
  output logic             busy,           // conversion sequence ongoing
  output logic             irq             // level interrupt
);
  logic rst_s1_ff; // reset sync stage one
  logic rst_n;     // reset sync stage two

  // release reset through two flip-flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  acf_pkg::acf_state_t      state_ff, nxt_state;  // sequencer state
  logic [1:0]               ctrl_ff, nxt_ctrl;    // mode and double buffer
  logic                     sequence_abort_request_ff, nxt_sequence_abort_request;    // abort pending
  logic                     restart_request_ff, nxt_restart_request;    // restart pending
  logic                     list_load_ok_ff, nxt_list_load_ok;    // load-ok pending
  logic                     list_ff, nxt_list;    // active list index
  logic [`ACF_IRQ_WIDTH-1:0] ist_ff, nxt_ist;     // sticky event status
  logic [`ACF_IRQ_WIDTH-1:0] imask_ff, nxt_imask; // interrupt mask
  logic [31:0]              rdata_ff, nxt_rdata;  // read data register
  logic                     samp_ff, nxt_samp;    // sampling start pulse
  logic                     top_ff, nxt_top;      // list top pulse
  logic                     tmr_start;            // start a timed wait
  logic [3:0]               tmr_count;            // length of the wait
  logic                     tmr_done;             // wait finished

  // write strobes decoded once
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic wr_flow; // write to flow control register
  logic w_sequence_abort_request;  // abort written
  logic w_trigger_request;  // trigger written
  logic w_restart_request;  // restart written
  logic w_list_load_ok;  // load-ok written
  acf_pkg::acf_mode_t mode; // selected flow mode
  assign wr_flow = wr & hit(addr, `ACF_ADDR_FLOW);
  assign w_sequence_abort_request  = wr_flow & wdata[`ACF_FLOW_SEQUENCE_ABORT_REQUEST_BIT];
  assign w_trigger_request  = wr_flow & wdata[`ACF_FLOW_TRIGGER_REQUEST_BIT];
  assign w_restart_request  = wr_flow & wdata[`ACF_FLOW_RESTART_REQUEST_BIT];
  assign w_list_load_ok  = wr_flow & wdata[`ACF_FLOW_LIST_LOAD_OK_BIT];
  assign mode    = acf_pkg::acf_mode_t'(ctrl_ff[`ACF_CTRL_MODE_BIT]);

  // one shared timer paces abort, load and trigger delay
  acf_delay u_delay
  (
    .clk   (clock),
    .rst_n (rst_n),
    .start (tmr_start),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // flow sequencer and event flags
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sequence_abort_request  = sequence_abort_request_ff | w_sequence_abort_request;
    nxt_restart_request  = restart_request_ff | w_restart_request;
    nxt_list_load_ok  = list_load_ok_ff | w_list_load_ok;
    nxt_list  = list_ff;
    nxt_ist   = ist_ff;
    nxt_samp  = 1'b0;
    nxt_top   = 1'b0;
    tmr_start = 1'b0;
    tmr_count = `ACF_LOAD_CYCLES;
    // write-one-to-clear; events below set later so set wins
    if (wr & hit(addr, `ACF_ADDR_IRQ_STAT))
    begin
      nxt_ist = ist_ff & ~wdata[`ACF_IRQ_WIDTH-1:0];
    end
    // trigger while a restart is unfinished: flag and drop it
    if (w_trigger_request && (restart_request_ff || w_restart_request || state_ff == acf_pkg::ST_LOAD))
    begin
      nxt_ist[`ACF_IRQ_TRIGGER_REQUEST_ERR_BIT] = 1'b1;
    end
    // restart into a busy converter with no abort pending
    if (w_restart_request && !restart_request_ff && !sequence_abort_request_ff && !w_sequence_abort_request &&
        (state_ff == acf_pkg::ST_CONVERT || state_ff == acf_pkg::ST_DELAY))
    begin
      nxt_sequence_abort_request = 1'b1;
      nxt_ist[`ACF_IRQ_RESTART_REQUEST_ERR_BIT] = 1'b1;
    end
    case (state_ff)
      acf_pkg::ST_IDLE, acf_pkg::ST_READY:
      begin
        if (nxt_sequence_abort_request)
        begin
          // idle already: abort still waits out the ACF_ABORT_CYCLES timer
          nxt_state = acf_pkg::ST_ABORT;
          tmr_start = 1'b1;
          tmr_count = `ACF_ABORT_CYCLES;
        end
        else if (nxt_restart_request)
        begin
          nxt_state = acf_pkg::ST_LOAD;
          tmr_start = 1'b1;
          tmr_count = `ACF_LOAD_CYCLES;
        end
        else if (state_ff == acf_pkg::ST_READY && w_trigger_request)
        begin
          // accepted trigger: fixed path to sampling
          nxt_state = acf_pkg::ST_DELAY;
          tmr_start = 1'b1;
          tmr_count = `ACF_TRIGGER_REQUEST_DELAY;
        end
      end
      acf_pkg::ST_ABORT:
      begin
        if (tmr_done)
        begin
          // an abort written in this very cycle survives: set wins
          nxt_sequence_abort_request  = w_sequence_abort_request;
          nxt_state = acf_pkg::ST_IDLE;
        end
      end
      acf_pkg::ST_LOAD:
      begin
        if (tmr_done)
        begin
          // swap only in double buffer mode
          if (list_load_ok_ff && ctrl_ff[`ACF_CTRL_DBUF_BIT])
          begin
            nxt_list = ~list_ff;
          end
          // bits written in the finishing cycle stay pending: set wins
          nxt_restart_request = w_restart_request;
          nxt_list_load_ok = w_list_load_ok;
          nxt_top  = 1'b1;
          if (mode == acf_pkg::MODE_TRIGGER)
          begin
            nxt_state = acf_pkg::ST_DELAY;
            tmr_start = 1'b1;
            tmr_count = `ACF_TRIGGER_REQUEST_DELAY;
          end
          else
          begin
            nxt_state = acf_pkg::ST_READY;
          end
        end
      end
      acf_pkg::ST_DELAY:
      begin
        if (nxt_sequence_abort_request)
        begin
          nxt_state = acf_pkg::ST_ABORT;
          tmr_start = 1'b1;
          tmr_count = `ACF_ABORT_CYCLES;
        end
        else if (tmr_done)
        begin
          nxt_samp  = 1'b1;
          nxt_state = acf_pkg::ST_CONVERT;
        end
      end
      acf_pkg::ST_CONVERT:
      begin
        if (nxt_sequence_abort_request)
        begin
          nxt_state = acf_pkg::ST_ABORT;
          tmr_start = 1'b1;
          tmr_count = `ACF_ABORT_CYCLES;
        end
        else if (seq_done)
        begin
          // next sequence waits for a trigger from the same list
          nxt_state = acf_pkg::ST_READY;
        end
      end
      default:
      begin
        nxt_state = acf_pkg::ST_IDLE;
      end
    endcase
  end

  // control, mask and read mux
  always_comb
  begin
    nxt_ctrl  = ctrl_ff;
    nxt_imask = imask_ff;
    nxt_rdata = 32'h0000_0000;
    if (wr & hit(addr, `ACF_ADDR_CTRL))
    begin
      nxt_ctrl = wdata[1:0];
    end
    if (wr & hit(addr, `ACF_ADDR_IRQ_MASK))
    begin
      nxt_imask = wdata[`ACF_IRQ_WIDTH-1:0];
    end
    if (rd)
    begin
      case (addr)
        `ACF_ADDR_CTRL:     nxt_rdata = {30'h0000_0000, ctrl_ff};
        `ACF_ADDR_FLOW:     nxt_rdata = {28'h000_0000, list_load_ok_ff, restart_request_ff, 1'b0, sequence_abort_request_ff};
        `ACF_ADDR_STATUS:   nxt_rdata = {27'h000_0000, state_ff, list_ff, busy};
        `ACF_ADDR_IRQ_STAT: nxt_rdata = {30'h0000_0000, ist_ff};
        `ACF_ADDR_IRQ_MASK: nxt_rdata = {30'h0000_0000, imask_ff};
        default:            nxt_rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // registers only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= acf_pkg::ST_IDLE;
      ctrl_ff  <= `ACF_CTRL_RESET;
      sequence_abort_request_ff  <= 1'b0;
      restart_request_ff  <= 1'b0;
      list_load_ok_ff  <= 1'b0;
      list_ff  <= 1'b0;
      ist_ff   <= `ACF_IRQ_RESET;
      imask_ff <= `ACF_IRQ_RESET;
      rdata_ff <= 32'h0000_0000;
      samp_ff  <= 1'b0;
      top_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ctrl_ff  <= nxt_ctrl;
      sequence_abort_request_ff  <= nxt_sequence_abort_request;
      restart_request_ff  <= nxt_restart_request;
      list_load_ok_ff  <= nxt_list_load_ok;
      list_ff  <= nxt_list;
      ist_ff   <= nxt_ist;
      imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata;
      samp_ff  <= nxt_samp;
      top_ff   <= nxt_top;
    end
  end

  // busy covers the delay and the running sequence
  assign busy         = (state_ff == acf_pkg::ST_DELAY) || (state_ff == acf_pkg::ST_CONVERT);
  assign rdata        = rdata_ff;
  assign sample_start = samp_ff;
  assign list_top     = top_ff;
  assign active_list  = list_ff;
  assign irq          = |(ist_ff & imask_ff);
endmodule

// >>> design/acf_cfg.svh
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH
// register word addresses (byte addresses, one aligned word each)
`define ACF_ADDR_CTRL     8'h00
`define ACF_ADDR_FLOW     8'h04
`define ACF_ADDR_STATUS   8'h08
`define ACF_ADDR_IRQ_STAT 8'h0C
`define ACF_ADDR_IRQ_MASK 8'h10
// ctrl fields
`define ACF_CTRL_MODE_BIT   0
`define ACF_CTRL_DBUF_BIT   1
`define ACF_CTRL_RESET      2'h0
// flow control fields (write one to request; all but trigger read back as pending)
`define ACF_FLOW_SEQUENCE_ABORT_REQUEST_BIT   0
`define ACF_FLOW_TRIGGER_REQUEST_BIT   1
`define ACF_FLOW_RESTART_REQUEST_BIT   2
`define ACF_FLOW_LIST_LOAD_OK_BIT   3
// status fields
`define ACF_STAT_BUSY_BIT   0
`define ACF_STAT_LIST_BIT   1
`define ACF_STAT_STATE_LSB  2
// interrupt status fields
`define ACF_IRQ_TRIGGER_REQUEST_ERR_BIT 0
`define ACF_IRQ_RESTART_REQUEST_ERR_BIT 1
`define ACF_IRQ_WIDTH        2
`define ACF_IRQ_RESET        2'h0
// timing counts in clock cycles
`define ACF_LOAD_CYCLES      4'h4
`define ACF_TRIGGER_REQUEST_DELAY       4'h3
`define ACF_ABORT_CYCLES     4'h2
`endif

// >>> design/acf_pkg.sv
package acf_pkg;
  // flow state of the converter sequencer
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ABORT   = 3'b001,
    ST_LOAD    = 3'b010,
    ST_READY   = 3'b011,
    ST_DELAY   = 3'b100,
    ST_CONVERT = 3'b101
  } acf_state_t;
  // flow control mode
  typedef enum logic {
    MODE_TRIGGER = 1'b0,
    MODE_RESTART = 1'b1
  } acf_mode_t;
endpackage

// >>> design/acf_delay.sv
`timescale 1ns/1ps
`include "acf_cfg.svh"
// loadable down counter; done pulses once when the count runs out
module acf_delay
(
  input  wire logic       clk,      // system clock
  input  wire logic       rst_n,    // synchronised reset, active low
  input  wire logic       start,    // load the count
  input  wire logic [3:0] count,    // cycles to wait, at least one
  output logic            done      // one-cycle pulse at the end
);
  logic [3:0] cnt_ff;   // remaining cycles
  logic [3:0] nxt_cnt;  // next remaining
  logic       done_ff;  // registered done
  logic       nxt_done; // next done

  // reload on start, otherwise count down to zero
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (start)
    begin
      nxt_cnt = count - 4'h1;
    end
    else if (cnt_ff != 4'h0)
    begin
      nxt_cnt = cnt_ff - 4'h1;
      nxt_done = (cnt_ff == 4'h1);
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= 4'h0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  logic start_q_ff;   // start seen last cycle
  logic cnt_q_one_ff; // that start asked for one cycle

  // a count of one finishes the cycle after start
  assign done = done_ff | (start_q_ff & cnt_q_one_ff);

  // remembers a one-cycle request, which the down counter cannot flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q_ff   <= 1'b0;
      cnt_q_one_ff <= 1'b0;
    end
    else
    begin
      start_q_ff   <= start;
      cnt_q_one_ff <= (count == 4'h1);
    end
  end
endmodule

// >>> bench/acf_flow_chk.sv
`timescale 1ns/1ps
// watches the flow block at its ports only
module acf_flow_chk
(
  input wire logic        clock,        // system clock
  input wire logic        arst_n,       // async reset, active low
  input wire logic [7:0]  addr,         // register address
  input wire logic [31:0] wdata,        // write data
  input wire logic        wr,           // write strobe
  input wire logic        rd,           // read strobe
  input wire logic [31:0] rdata,        // read data
  input wire logic        seq_done,     // sequence finished
  input wire logic        sample_start, // sampling pulse
  input wire logic        list_top,     // restart finished pulse
  input wire logic        active_list,  // selected list
  input wire logic        busy,         // conversion ongoing
  input wire logic        irq           // interrupt level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // read data only in the slot after a read
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (rd && addr > 8'h10 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SS_PULSE: assert property (sample_start |=> !sample_start)
    else $error("sampling pulse too long");
  AST_TOP_PULSE: assert property (list_top |=> !list_top)
    else $error("list top pulse too long");
  // list changes only as a restart finishes
  AST_SWAP: assert property ($changed(active_list) |-> list_top || $past(list_top))
    else $error("list swapped without restart");
  // nothing converts without restart or trigger
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> list_top || $past(list_top) || $past(wr) || $past(wr, 2))
    else $error("conversion without cause");
  // an abort during the delay legally ends busy with no sampling
  AST_DELAY_BOUND: assert property ($rose(busy) |-> ##[1:8] (sample_start || !busy))
    else $error("sampling start late");
  AST_SEQ_END: assert property ($past(sample_start) && seq_done |=> !busy)
    else $error("busy after sequence end");
endmodule
bind acf_flow acf_flow_chk u_chk (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .seq_done(seq_done), .sample_start(sample_start), .list_top(list_top),
  .active_list(active_list), .busy(busy), .irq(irq));

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;    // system clock
  logic        arst_n = 1'b0;   // reset, active low
  logic [7:0]  addr = 8'h00;    // register address
  logic [31:0] wdata = 32'h0;   // write data
  logic        wr = 1'b0;       // write strobe
  logic        rd = 1'b0;       // read strobe
  logic [31:0] rdata;           // read data
  logic        seq_done = 1'b0; // sequence finished
  logic        sample_start;    // sampling pulse
  logic        list_top;        // restart finished
  logic        active_list;     // selected list
  logic        busy;            // conversion ongoing
  logic        irq;             // interrupt
  int          n_errors = 0;    // mismatches
  int          compares = 0;    // comparisons
  int          n1;              // cycle counts
  int          n2;
  always #10 clock = ~clock;
  acf_flow dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .seq_done(seq_done), .sample_start(sample_start), .list_top(list_top), .active_list(active_list),
    .busy(busy), .irq(irq));
  task finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle bus write, a free edge after it
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // bounded wait for list_top (0) or sample_start (1)
  // a pulse already standing at the call counts, with n at zero
  task wt(input logic s, output int n);
    n = 0;
    while ((s ? sample_start : list_top) !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > 40)
      begin
        n_errors++;
        finish_test();
      end
    end
  endtask
  // end the conversion one cycle after it starts
  task seq;
    @(posedge clock);
    seq_done <= 1'b1;
    @(posedge clock);
    seq_done <= 1'b0;
    #1;
  endtask
  task t_reset;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h20, 32'h0);
    $display("reset done");
  endtask
  task t_trigger_request;
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h04, 32'h4);
    wt(0, n1);
    wt(1, n1);
    chk(busy, 1'b1);
    seq();
    chk(busy, 1'b0);
    $display("trigger mode done");
  endtask
  task t_restart_request;
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h04, 32'h4);
    wr_reg(8'h04, 32'h2);
    rchk(8'h0C, 32'h1);
    chk(irq, 1'b0);
    // loading ends just as this read returns
    wt(0, n1);
    repeat (8) @(posedge clock);
    rchk(8'h08, 32'hC);
    rchk(8'h04, 32'h0);
    wr_reg(8'h04, 32'h2);
    wt(1, n1);
    seq();
    wr_reg(8'h04, 32'h2);
    wt(1, n2);
    chk(n2, n1);
    seq();
    wr_reg(8'h0C, 32'h1);
    rchk(8'h0C, 32'h0);
    $display("restart mode done");
  endtask
  task t_swap;
    wr_reg(8'h00, 32'h3);
    wr_reg(8'h04, 32'hC);
    wt(0, n1);
    rchk(8'h08, 32'hE);
    chk(active_list, 1'b1);
    wr_reg(8'h04, 32'h2);
    wt(1, n1);
    seq();
    wr_reg(8'h00, 32'h2);
    wr_reg(8'h04, 32'hC);
    wt(1, n1);
    chk(active_list, 1'b0);
    seq();
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h04, 32'hC);
    wt(1, n1);
    chk(active_list, 1'b0);
    seq();
    $display("swap done");
  endtask
  task t_abort;
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h04, 32'h4);
    wt(0, n1);
    wr_reg(8'h04, 32'h2);
    wt(1, n1);
    wr_reg(8'h04, 32'h4);
    wt(0, n1);
    chk(irq, 1'b1);
    rchk(8'h0C, 32'h2);
    chk(busy, 1'b0);
    wr_reg(8'h0C, 32'h3);
    chk(irq, 1'b0);
    wr_reg(8'h04, 32'h2);
    wt(1, n1);
    wr_reg(8'h04, 32'h1);
    repeat (6) @(posedge clock);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    $display("abort done");
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_trigger_request();
    t_restart_request();
    t_swap();
    t_abort();
    // unless a wt wait times out, the run stops at a sequence boundary
    chk(busy, 1'b0);
    finish_test();
  end
endmodule
